//--- dv/scip_core_regs_sva.sv
// port assertions for the low core register block
// assumes every access is answered one cycle after it is taken
`timescale 1ns/10ps
`default_nettype none
`include "scip_regs.vh"
module scip_core_regs_chk (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic net_wr_i,
	input wire logic net_rd_i,
	input wire logic [`SCIP_AW-1:0] net_addr_i,
	input wire logic [7:0] net_rdata_o,
	input wire logic net_wr_ok_o,
	input wire logic net_wr_blocked_o,
	input wire logic host_wr_i,
	input wire logic cfg_alias_load_i,
	input wire logic alias_enable_i,
	input wire logic [15:0] net_node_addr_i,
	input wire logic node_match_o,
	input wire logic [15:0] station_node_address_o,
	input wire logic [15:0] station_alias_address_o,
	input wire logic net_side_reset_o
);
// the internal reset copy trails nrst_i by two edges, so hold off until it is gone
logic [1:0] up_cnt;
wire up = (up_cnt == 2'h3);
always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i)
		up_cnt <= 2'h0;
	else if (!up)
		up_cnt <= up_cnt + 2'h1;
end
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!nrst_i);
////////////////////////////////////////////////////////////////////////
property p_wr_answer; up && net_wr_i |=> net_wr_ok_o != net_wr_blocked_o; endproperty
a_wr_answer: assert property (p_wr_answer) else $error("write without one status pulse");
property p_feat_lo; up && net_rd_i && net_addr_i == `SCIP_OFS_FEAT_LO |=> net_rdata_o == 8'hcc; endproperty
a_feat_lo: assert property (p_feat_lo) else $error("capability low byte wrong");
property p_feat_hi; up && net_rd_i && net_addr_i == `SCIP_OFS_FEAT_HI |=> net_rdata_o == 8'h01; endproperty
a_feat_hi: assert property (p_feat_hi) else $error("capability high byte wrong");
property p_blocked_keep; up && net_wr_blocked_o |-> $stable(station_node_address_o); endproperty
a_blocked_keep: assert property (p_blocked_keep) else $error("blocked write changed station");
property p_node_host_ro; up && host_wr_i && !net_wr_i |=> $stable(station_node_address_o); endproperty
a_node_host_ro: assert property (p_node_host_ro) else $error("host changed station");
property p_alias_net_ro; up && net_wr_i && !host_wr_i && !cfg_alias_load_i |=> $stable(station_alias_address_o); endproperty
a_alias_net_ro: assert property (p_alias_net_ro) else $error("network changed alias");
property p_match; up |=> node_match_o == ($past(net_node_addr_i) == $past(station_node_address_o) ||
	$past(alias_enable_i) && $past(net_node_addr_i) == $past(station_alias_address_o)); endproperty
a_match: assert property (p_match) else $error("node match wrong");
property p_key_rsv; up && net_rd_i && net_addr_i == `SCIP_OFS_RESET_KEY |=> net_rdata_o[7:2] == 6'h00; endproperty
a_key_rsv: assert property (p_key_rsv) else $error("reset key upper bits set");
property p_reset_pulse; up && net_side_reset_o |=> !net_side_reset_o; endproperty
a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
c_blocked: cover property (net_wr_blocked_o);
c_reset: cover property (net_side_reset_o);
c_alias_match: cover property (node_match_o && alias_enable_i);
endmodule
bind scip_core_regs scip_core_regs_chk i_scip_core_regs_chk (.clk_sys_i, .nrst_i, .net_wr_i, .net_rd_i, .net_addr_i,
	.net_rdata_o, .net_wr_ok_o, .net_wr_blocked_o, .host_wr_i, .cfg_alias_load_i, .alias_enable_i,
	.net_node_addr_i, .node_match_o, .station_node_address_o, .station_alias_address_o, .net_side_reset_o);
`default_nettype wire

//--- dv/scip_core_regs_tb_top.sv
// self-checking bench for the low core register block
// assumes the network master model drives the network port
`timescale 1ns/10ps
`default_nettype none
`include "scip_regs.vh"
module scip_core_regs_tb_top;
logic clk_sys_i, nrst_i, host_wr_i, host_rd_i, cfg_alias_load_i, alias_enable_i;
logic [13:0] host_addr_i;
logic [7:0] host_wdata_i, r;
logic [15:0] cfg_alias_i, net_node_addr_i;
wire net_frame_start_i, net_wr_i, net_rd_i, net_rvalid_o, net_wr_ok_o, net_wr_blocked_o;
wire host_rvalid_o, node_match_o, net_side_reset_o;
wire [13:0] net_addr_i;
wire [7:0] net_wdata_i, net_rdata_o, host_rdata_o;
wire [15:0] station_node_address_o, station_alias_address_o;
int error_cnt = 0;
int checks_done = 0;
scip_core_regs i_scip_core_regs (.clk_sys_i, .nrst_i, .net_frame_start_i, .net_wr_i, .net_rd_i, .net_addr_i,
	.net_wdata_i, .net_rdata_o, .net_rvalid_o, .net_wr_ok_o, .net_wr_blocked_o, .host_wr_i, .host_rd_i,
	.host_addr_i, .host_wdata_i, .host_rdata_o, .host_rvalid_o, .cfg_alias_load_i, .cfg_alias_i,
	.alias_enable_i, .net_node_addr_i, .node_match_o, .station_node_address_o, .station_alias_address_o,
	.net_side_reset_o);
scip_net_master i_scip_net_master (.clk_i(clk_sys_i), .ok_i(net_wr_ok_o), .blk_i(net_wr_blocked_o),
	.rdata_i(net_rdata_o), .frame_o(net_frame_start_i), .wr_o(net_wr_i), .rd_o(net_rd_i),
	.addr_o(net_addr_i), .wdata_o(net_wdata_i));
////////////////////////////////////////////////////////////////////////
task check(input logic [15:0] seen, input logic [15:0] exp);
	checks_done++;
	if (seen !== exp) begin
		error_cnt++;
		$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task stop_test;
	if (error_cnt == 0 && checks_done > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
// exp 2'h1 accepted, 2'h2 refused
task nw(input logic [13:0] a, input logic [7:0] d, input logic [1:0] exp);
	i_scip_net_master.cmd(1'b1, a, d, r);
	check(r, {14'h0, exp});
endtask
task nr(input logic [13:0] a, input logic [7:0] exp);
	i_scip_net_master.cmd(1'b0, a, 8'h00, r);
	check(r, exp);
	check(net_rvalid_o, 16'h1);
endtask
task hw(input logic [13:0] a, input logic [7:0] d);
	@(posedge clk_sys_i) #1;
	{host_wr_i, host_addr_i, host_wdata_i} = {1'b1, a, d};
	@(posedge clk_sys_i) #1;
	{host_wr_i, host_addr_i, host_wdata_i} = {1'b0, ~a, ~d};
endtask
task hr(input logic [13:0] a, input logic [7:0] exp);
	@(posedge clk_sys_i) #1;
	{host_rd_i, host_addr_i} = {1'b1, a};
	@(posedge clk_sys_i) #1;
	{host_rd_i, host_addr_i} = {1'b0, ~a};
	check(host_rdata_o, exp);
	check(host_rvalid_o, 16'h1);
endtask
task tick;
	@(posedge clk_sys_i) #1;
endtask
////////////////////////////////////////////////////////////////////////
task t_capability;
	nr(`SCIP_OFS_FEAT_LO, 8'hcc);
	nr(`SCIP_OFS_FEAT_HI, 8'h01);
	hr(`SCIP_OFS_FEAT_LO, 8'hcc);
	hr(`SCIP_OFS_FEAT_HI, 8'h01);
endtask
task t_station;
	nr(`SCIP_OFS_NODE_LO, 8'h00);
	nw(`SCIP_OFS_NODE_LO, 8'h34, 2'h1);
	nw(`SCIP_OFS_NODE_HI, 8'h12, 2'h1);
	check(station_node_address_o, 16'h1234);
	hw(`SCIP_OFS_NODE_LO, 8'h99);
	hr(`SCIP_OFS_NODE_LO, 8'h34);
	net_node_addr_i = 16'h1234;
	tick;
	check(node_match_o, 16'h1);
endtask
task t_alias;
	{cfg_alias_load_i, cfg_alias_i} = {1'b1, 16'hbeef};
	tick;
	{cfg_alias_load_i, cfg_alias_i} = {1'b1, 16'h4321};
	tick;
	cfg_alias_load_i = 1'b0;
	check(station_alias_address_o, 16'hbeef);
	hw(`SCIP_OFS_ALIAS_HI, 8'h43);
	nw(`SCIP_OFS_ALIAS_LO, 8'h00, 2'h1);
	check(station_alias_address_o, 16'h43ef);
	{alias_enable_i, net_node_addr_i} = {1'b0, 16'h43ef};
	tick;
	check(node_match_o, 16'h0);
	alias_enable_i = 1'b1;
	tick;
	check(node_match_o, 16'h1);
endtask
task t_reg_guard;
	i_scip_net_master.frame;
	nw(`SCIP_OFS_REG_GUARD, 8'hff, 2'h1);
	nr(`SCIP_OFS_REG_GUARD, 8'h01);
	nw(`SCIP_OFS_NODE_LO, 8'h55, 2'h2);
	check(station_node_address_o, 16'h1234);
	nw(`SCIP_OFS_REG_UNLOCK, 8'h5a, 2'h1);
	nw(`SCIP_OFS_NODE_LO, 8'h56, 2'h1);
	i_scip_net_master.frame;
	nw(`SCIP_OFS_NODE_LO, 8'h57, 2'h2);
	nw(14'h0f80, 8'h00, 2'h1);
	nw(`SCIP_OFS_REG_UNLOCK, 8'h00, 2'h1);
	nw(`SCIP_OFS_REG_GUARD, 8'h00, 2'h1);
	check(station_node_address_o, 16'h1256);
endtask
task t_full_guard;
	nw(`SCIP_OFS_FULL_GUARD, 8'h01, 2'h1);
	i_scip_net_master.frame;
	nw(14'h0f80, 8'h00, 2'h2);
	nw(`SCIP_OFS_FULL_UNLOCK, 8'h00, 2'h1);
	nw(14'h0f80, 8'h00, 2'h1);
	i_scip_net_master.frame;
	nw(`SCIP_OFS_RESET_KEY, 8'h52, 2'h2);
	nw(`SCIP_OFS_FULL_UNLOCK, 8'h00, 2'h1);
	nw(`SCIP_OFS_FULL_GUARD, 8'h00, 2'h1);
	nr(`SCIP_OFS_FULL_GUARD, 8'h00);
endtask
task t_reset_key;
	hr(`SCIP_OFS_RESET_KEY, 8'h00);
	nw(`SCIP_OFS_RESET_KEY, `SCIP_KEY_FIRST, 2'h1);
	nr(`SCIP_OFS_RESET_KEY, 8'h01);
	nw(`SCIP_OFS_RESET_KEY, `SCIP_KEY_SECOND, 2'h1);
	nr(`SCIP_OFS_RESET_KEY, 8'h02);
	nw(`SCIP_OFS_RESET_KEY, 8'h00, 2'h1);
	nr(`SCIP_OFS_RESET_KEY, 8'h00);
	hw(`SCIP_OFS_RESET_KEY, `SCIP_KEY_FIRST);
	hr(`SCIP_OFS_RESET_KEY, 8'h00);
	nw(`SCIP_OFS_RESET_KEY, `SCIP_KEY_FIRST, 2'h1);
	nw(`SCIP_OFS_RESET_KEY, `SCIP_KEY_SECOND, 2'h1);
	nw(`SCIP_OFS_RESET_KEY, `SCIP_KEY_THIRD, 2'h1);
	check(net_side_reset_o, 16'h0);
	tick;
	check(net_side_reset_o, 16'h1);
	tick;
	check(net_side_reset_o, 16'h0);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	clk_sys_i = 1'b0;
	forever #2.5 clk_sys_i = ~clk_sys_i;
end
initial begin
	#100us;
	error_cnt++;
	stop_test;
end
initial begin
	{nrst_i, host_wr_i, host_rd_i, cfg_alias_load_i, alias_enable_i} = 5'h00;
	{host_addr_i, host_wdata_i, cfg_alias_i, net_node_addr_i} = 54'h0;
	repeat (16) @(posedge clk_sys_i);
	#1 nrst_i = 1'b1;
	repeat (3) @(posedge clk_sys_i);
	t_capability;
	t_station;
	t_alias;
	t_reg_guard;
	t_full_guard;
	t_reset_key;
	stop_test;
end
endmodule
`default_nettype wire

//--- dv/scip_net_master.sv
// network master model: frame markers and byte commands
// assumes the block answers each command on the next edge
`timescale 1ns/10ps
`default_nettype none
module scip_net_master (
	input wire logic clk_i,
	input wire logic ok_i,
	input wire logic blk_i,
	input wire logic [7:0] rdata_i,
	output logic frame_o,
	output logic wr_o,
	output logic rd_o,
	output logic [13:0] addr_o,
	output logic [7:0] wdata_o
);
initial begin
	frame_o = 1'b0;
	wr_o = 1'b0;
	rd_o = 1'b0;
	addr_o = 14'h0000;
	wdata_o = 8'h00;
end
task frame;
	@(posedge clk_i) #1;
	frame_o = 1'b1;
	@(posedge clk_i) #1;
	frame_o = 1'b0;
endtask
// w=1 returns {blocked, ok}, w=0 returns read byte; released lines show inverted junk
task cmd(input logic w, input logic [13:0] a, input logic [7:0] d, output logic [7:0] r);
	@(posedge clk_i) #1;
	wr_o = w;
	rd_o = !w;
	addr_o = a;
	wdata_o = d;
	@(posedge clk_i) #1;
	r = w ? {6'h00, blk_i, ok_i} : rdata_i;
	wr_o = 1'b0;
	rd_o = 1'b0;
	addr_o = ~a;
	wdata_o = ~d;
endtask
endmodule
`default_nettype wire

//--- rtl/scip_core_regs.v
// low control and status registers of the slave controller core:
// capability word, station address and alias, write protection, reset key
// assumes both access ports and the frame markers run on clk_sys_i
`timescale 1ns/10ps
`default_nettype none
`include "scip_regs.vh"

module scip_core_regs (
	input wire clk_sys_i,
	input wire nrst_i,
	input wire net_frame_start_i,
	input wire net_wr_i,
	input wire net_rd_i,
	input wire [`SCIP_AW-1:0] net_addr_i,
	input wire [7:0] net_wdata_i,
	output reg [7:0] net_rdata_o,
	output reg net_rvalid_o,
	output reg net_wr_ok_o,
	output reg net_wr_blocked_o,
	input wire host_wr_i,
	input wire host_rd_i,
	input wire [`SCIP_AW-1:0] host_addr_i,
	input wire [7:0] host_wdata_i,
	output reg [7:0] host_rdata_o,
	output reg host_rvalid_o,
	input wire cfg_alias_load_i,
	input wire [15:0] cfg_alias_i,
	input wire alias_enable_i,
	input wire [15:0] net_node_addr_i,
	output reg node_match_o,
	output reg [15:0] station_node_address_o,
	output reg [15:0] station_alias_address_o,
	output reg net_side_reset_o
);

////////////////////////////////////////////////////////////////////////////////
// reset release

reg rst_n_q1;
reg rst_n;

always @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i) begin
		rst_n_q1 <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_n_q1 <= 1'b1;
		rst_n <= rst_n_q1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// storage

reg reg_unlock_bit;
reg reg_guard_bit;
reg full_unlock_bit;
reg full_guard_bit;
reg alias_loaded;

wire net_allow;
wire net_wr_taken;
wire reg_frame_unlock;
wire full_frame_unlock;
wire [1:0] key_progress;
wire key_fire;

assign net_wr_taken = net_wr_i && net_allow;

////////////////////////////////////////////////////////////////////////////////
// protection tracking and reset key

scip_write_gate u_gate (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n),
	.frame_start_i(net_frame_start_i),
	.wr_i(net_wr_i),
	.addr_i(net_addr_i),
	.reg_guard_i(reg_guard_bit),
	.full_guard_i(full_guard_bit),
	.allow_o(net_allow),
	.reg_unlock_o(reg_frame_unlock),
	.full_unlock_o(full_frame_unlock)
);

// the key only sees writes that got past protection, so a locked
// station cannot be reset by a master that skipped the unlock
scip_reset_key u_key (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n),
	.wr_i(net_wr_taken && (net_addr_i == `SCIP_OFS_RESET_KEY)),
	.wdata_i(net_wdata_i),
	.progress_o(key_progress),
	.fire_o(key_fire)
);

////////////////////////////////////////////////////////////////////////////////
// capability word, fixed; reserved bits 15:12 and 1 are zero in the constant

wire [15:0] feature_word;

assign feature_word = `SCIP_FEATURE_WORD;

////////////////////////////////////////////////////////////////////////////////
// read decode, shared by both ports

function [7:0] rd_byte;
	input [`SCIP_AW-1:0] addr;
	begin
		case (addr)
			`SCIP_OFS_FEAT_LO: begin
				rd_byte = feature_word[7:0];
			end
			`SCIP_OFS_FEAT_HI: begin
				rd_byte = feature_word[15:8];
			end
			`SCIP_OFS_NODE_LO: begin
				rd_byte = station_node_address_o[7:0];
			end
			`SCIP_OFS_NODE_HI: begin
				rd_byte = station_node_address_o[15:8];
			end
			`SCIP_OFS_ALIAS_LO: begin
				rd_byte = station_alias_address_o[7:0];
			end
			`SCIP_OFS_ALIAS_HI: begin
				rd_byte = station_alias_address_o[15:8];
			end
			`SCIP_OFS_REG_UNLOCK: begin
				rd_byte = {7'h00, reg_unlock_bit};
			end
			`SCIP_OFS_REG_GUARD: begin
				rd_byte = {7'h00, reg_guard_bit};
			end
			`SCIP_OFS_FULL_UNLOCK: begin
				rd_byte = {7'h00, full_unlock_bit};
			end
			`SCIP_OFS_FULL_GUARD: begin
				rd_byte = {7'h00, full_guard_bit};
			end
			`SCIP_OFS_RESET_KEY: begin
				rd_byte = {6'h00, key_progress};
			end
			default: begin
				rd_byte = `SCIP_BYTE_RESET;
			end
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// byte lane merge for the 16-bit registers: low byte at the even address,
// high byte at the odd one; the other lane keeps its value

function [15:0] put_byte;
	input [15:0] old_word;
	input high_lane;
	input [7:0] new_byte;
	begin
		if (high_lane)
			put_byte = {new_byte, old_word[7:0]};
		else
			put_byte = {old_word[15:8], new_byte};
	end
endfunction

// both bytes of a 16-bit register share every address bit but the lowest
function hits_word;
	input [`SCIP_AW-1:0] addr;
	input [`SCIP_AW-1:0] base;
	begin
		hits_word = (addr[`SCIP_AW-1:1] == base[`SCIP_AW-1:1]);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// network side read port, one cycle latency

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		net_rdata_o <= `SCIP_BYTE_RESET;
		net_rvalid_o <= 1'b0;
	end else begin
		net_rvalid_o <= net_rd_i;
		if (net_rd_i)
			net_rdata_o <= rd_byte(net_addr_i);
	end
end

////////////////////////////////////////////////////////////////////////////////
// host side read port, one cycle latency

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		host_rdata_o <= `SCIP_BYTE_RESET;
		host_rvalid_o <= 1'b0;
	end else begin
		host_rvalid_o <= host_rd_i;
		if (host_rd_i)
			host_rdata_o <= rd_byte(host_addr_i);
	end
end

////////////////////////////////////////////////////////////////////////////////
// network write status, reported for every write seen on the port

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		net_wr_ok_o <= 1'b0;
		net_wr_blocked_o <= 1'b0;
	end else begin
		net_wr_ok_o <= net_wr_taken;
		net_wr_blocked_o <= net_wr_i && !net_allow;
	end
end

////////////////////////////////////////////////////////////////////////////////
// station address: network writable only

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		station_node_address_o <= `SCIP_NODE_RESET;
	end else if (net_wr_taken && hits_word(net_addr_i, `SCIP_OFS_NODE_LO)) begin
		// a blocked write never reaches here, so the value holds
		station_node_address_o <= put_byte(station_node_address_o, net_addr_i[0], net_wdata_i);
	end
end

////////////////////////////////////////////////////////////////////////////////
// station alias: host writes and the first configuration load only.
// the loaded flag survives the network reset on purpose, it is cleared
// by the power-on reset alone

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		station_alias_address_o <= `SCIP_ALIAS_RESET;
		alias_loaded <= 1'b0;
	end else begin
		if (cfg_alias_load_i && !alias_loaded) begin
			station_alias_address_o <= cfg_alias_i;
			alias_loaded <= 1'b1;
		end else if (host_wr_i && hits_word(host_addr_i, `SCIP_OFS_ALIAS_LO)) begin
			station_alias_address_o <= put_byte(station_alias_address_o, host_addr_i[0], host_wdata_i);
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// guard bits, network writable; upper bits are not stored.
// a change steers the very next write, not the current one

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		reg_guard_bit <= 1'b0;
		full_guard_bit <= 1'b0;
	end else if (net_wr_taken) begin
		if (net_addr_i == `SCIP_OFS_REG_GUARD)
			reg_guard_bit <= net_wdata_i[`SCIP_ENABLE_BIT];
		if (net_addr_i == `SCIP_OFS_FULL_GUARD)
			full_guard_bit <= net_wdata_i[`SCIP_ENABLE_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////////
// unlock bits only echo what was written; the per-frame unlock itself
// lives in the write gate and is cleared by a frame start unless an unlock write comes in that cycle

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		reg_unlock_bit <= 1'b0;
		full_unlock_bit <= 1'b0;
	end else if (net_wr_taken) begin
		if (net_addr_i == `SCIP_OFS_REG_UNLOCK)
			reg_unlock_bit <= net_wdata_i[`SCIP_ENABLE_BIT];
		if (net_addr_i == `SCIP_OFS_FULL_UNLOCK)
			full_unlock_bit <= net_wdata_i[`SCIP_ENABLE_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////////
// node address match for configured-address commands

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		node_match_o <= 1'b0;
	end else begin
		node_match_o <= (net_node_addr_i == station_node_address_o) ||
			(alias_enable_i && (net_node_addr_i == station_alias_address_o));
	end
end

////////////////////////////////////////////////////////////////////////////////
// network side reset request, two cycles after the third key write is taken

always @(posedge clk_sys_i or negedge rst_n) begin
	if (!rst_n) begin
		net_side_reset_o <= 1'b0;
	end else begin
		net_side_reset_o <= key_fire;
	end
end

endmodule
`default_nettype wire

//--- rtl/scip_regs.vh
// offsets, field positions, reset values and codes of the low core registers
// assumes byte-wide access ports, one byte address per access
// How it works
// - capability bits 11, 10, 9 read zero: variable config, both command kinds.
// - capability bit 8 reads one: enhanced sync-pulse activation present.
// - capability bit 7 reads one: bad-checksum frames counted separately.
// - capability bit 6 reads one; bits 5 and 4 read zero.
// - capability bits 2 and 3 read one: time-keeping present, 64-bit wide.
// - capability bit 0 reads zero: address mapping is bit oriented.
// - multi-byte registers keep the low byte at the lowest address.
// - station address resets to zero, network writable, host read-only, matched.
// - alias writable from host only; config load taken on first load only.
// - alias matched only while the alias-enable bit is set.
// - alias-enable one: alias serves all configured-address commands; zero ignores it.
// - register guard bit 0 blocks writes 0000h-0F7Fh except 0020h and 0030h.
// - under register guard, a write to 0020h earlier in frame unlocks writes.
// - register unlock lasts for its frame only; guard stays in force.
// - full guard bit 0 blocks every write except to 0030h.
// - under full guard, a write to 0030h earlier in frame unlocks writes.
// - writes 52h, 45h, 53h in three consecutive commands fire the reset.
// - reset key reads progress 01 after 52h, 10 after 52h-45h, else 00.
// - reset key is network writable, host read-only, resets to 00h.
`ifndef SCIP_REGS_VH
`define SCIP_REGS_VH

`define SCIP_AW 14
`define SCIP_OFS_FEAT_LO 14'h0008
`define SCIP_OFS_FEAT_HI 14'h0009
`define SCIP_OFS_NODE_LO 14'h0010
`define SCIP_OFS_NODE_HI 14'h0011
`define SCIP_OFS_ALIAS_LO 14'h0012
`define SCIP_OFS_ALIAS_HI 14'h0013
`define SCIP_OFS_REG_UNLOCK 14'h0020
`define SCIP_OFS_REG_GUARD 14'h0021
`define SCIP_OFS_FULL_UNLOCK 14'h0030
`define SCIP_OFS_FULL_GUARD 14'h0031
`define SCIP_OFS_RESET_KEY 14'h0040
`define SCIP_GUARD_TOP 14'h0f7f

`define SCIP_FEATURE_WORD 16'h01cc
`define SCIP_NODE_RESET 16'h0000
`define SCIP_ALIAS_RESET 16'h0000
`define SCIP_BYTE_RESET 8'h00
`define SCIP_ENABLE_BIT 0

`define SCIP_KEY_FIRST 8'h52
`define SCIP_KEY_SECOND 8'h45
`define SCIP_KEY_THIRD 8'h53
`define SCIP_PROG_NONE 2'h0
`define SCIP_PROG_FIRST 2'h1
`define SCIP_PROG_SECOND 2'h2

`endif

//--- rtl/scip_reset_key.v
// three-write reset key sequence on the network side
// assumes wr_i is already qualified by address and write protection
`timescale 1ns/10ps
`default_nettype none
`include "scip_regs.vh"

module scip_reset_key (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire wr_i,
	input wire [7:0] wdata_i,
	output reg [1:0] progress_o,
	output reg fire_o
);

localparam ST_IDLE = 2'd0;
localparam ST_FIRST = 2'd1;
localparam ST_SECOND = 2'd2;

reg [1:0] state;
reg [1:0] next_state;
reg next_fire;

always @* begin
	next_state = state;
	next_fire = 1'b0;
	if (wr_i) begin
		// any other value breaks the sequence; 52h always restarts it
		case (state)
			ST_IDLE: begin
				next_state = (wdata_i == `SCIP_KEY_FIRST) ? ST_FIRST : ST_IDLE;
			end
			ST_FIRST: begin
				if (wdata_i == `SCIP_KEY_SECOND)
					next_state = ST_SECOND;
				else
					next_state = (wdata_i == `SCIP_KEY_FIRST) ? ST_FIRST : ST_IDLE;
			end
			ST_SECOND: begin
				if (wdata_i == `SCIP_KEY_THIRD) begin
					next_state = ST_IDLE;
					next_fire = 1'b1;
				end else begin
					next_state = (wdata_i == `SCIP_KEY_FIRST) ? ST_FIRST : ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end
end

always @(posedge clk_sys_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		state <= ST_IDLE;
		progress_o <= `SCIP_PROG_NONE;
		fire_o <= 1'b0;
	end else begin
		state <= next_state;
		fire_o <= next_fire;
		case (next_state)
			ST_FIRST: progress_o <= `SCIP_PROG_FIRST;
			ST_SECOND: progress_o <= `SCIP_PROG_SECOND;
			default: progress_o <= `SCIP_PROG_NONE;
		endcase
	end
end

endmodule
`default_nettype wire

//--- rtl/scip_write_gate.v
// per-frame write unlock tracking for the two protection levels
// assumes frame_start_i pulses once before the first command of each frame
`timescale 1ns/10ps
`default_nettype none
`include "scip_regs.vh"

module scip_write_gate (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire frame_start_i,
	input wire wr_i,
	input wire [`SCIP_AW-1:0] addr_i,
	input wire reg_guard_i,
	input wire full_guard_i,
	output wire allow_o,
	output reg reg_unlock_o,
	output reg full_unlock_o
);

wire is_reg_unlock;
wire is_full_unlock;
wire full_ok;
wire reg_ok;

assign is_reg_unlock = (addr_i == `SCIP_OFS_REG_UNLOCK);
assign is_full_unlock = (addr_i == `SCIP_OFS_FULL_UNLOCK);
assign full_ok = !full_guard_i || full_unlock_o || is_full_unlock;
assign reg_ok = !reg_guard_i || reg_unlock_o || is_reg_unlock || is_full_unlock ||
	(addr_i > `SCIP_GUARD_TOP);
assign allow_o = full_ok && reg_ok;

////////////////////////////////////////////////////////////////////////////////
// a frame start clears the unlock, but a write in that same cycle already
// belongs to the new frame, so the set wins
always @(posedge clk_sys_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		reg_unlock_o <= 1'b0;
		full_unlock_o <= 1'b0;
	end else begin
		if (wr_i && allow_o && is_reg_unlock)
			reg_unlock_o <= 1'b1;
		else if (frame_start_i)
			reg_unlock_o <= 1'b0;
		if (wr_i && is_full_unlock)
			full_unlock_o <= 1'b1;
		else if (frame_start_i)
			full_unlock_o <= 1'b0;
	end
end

endmodule
`default_nettype wire
